// ---- rtl/hbdsp_port.sv ----
// Overview of operation
// - A host write waits only when it hits the buffer port while the network holds the buffer.
// - On a network error during a buffer port conflict, for a read or a write, the wait may last up to 2.15 us before ready returns.
// - Ready returns within 28 ns normally and within 175 ns after a network conflict.
// - A strap picks whether ready is active high or active low.
// - In single dma the request drops within 21 ns of acknowledge and returns within 19 ns of its release.
// - Bit 1 of the link config control picks the end-of-process polarity.
// - In burst dma the request drops one cycle before the last transfer when transmit mode bit 2 is set, else at it.
// - During dma the wait output behaves as for ordinary accesses.
// - A host read waits only when it hits the buffer port while the network holds the buffer.
module hbdsp_port
	import hbdsp_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic host_read_strobe_i,
	input wire logic host_write_strobe_i,
	input wire logic buffer_memory_port_sel_i,
	input wire logic ready_polarity_strap_i,
	input wire logic net_req_i,
	input wire logic net_err_i,
	input wire logic dma_pending_i,
	input wire logic burst_mode_i,
	input wire logic dma_acknowledge_in_i,
	input wire logic end_of_process_in_i,
	input wire logic next_last_i,
	input wire logic [7:0] link_config_control_i,
	input wire logic [7:0] transmit_mode_control_i,
	output logic channel_wait_output_o,
	output logic host_grant_o,
	output logic net_grant_o,
	output logic eop_seen_o,
	output logic inhibit_violation_o,
	output logic dma_request_out_o
);

	hbdsp_host_type host;
	hbdsp_net_type net;
	hbdsp_state_type state_r;
	hbdsp_state_type state_nxt;
	logic [8:0] wait_cnt_r;
	logic [8:0] wait_cnt_nxt;
	logic strap_r;
	logic ready_r;
	logic ready_nxt;
	logic strobe_prev_r;
	logic [3:0] idle_cnt_r;
	logic eop_act;
	logic net_owner_r;
	logic access;
	logic bmp_access;

	assign host = '{rd: host_read_strobe_i, wr: host_write_strobe_i, bmp_sel: buffer_memory_port_sel_i};
	assign net = '{req: net_req_i, err: net_err_i};
	assign access = host.rd | host.wr;
	assign bmp_access = access & host.bmp_sel;

	assign eop_act = end_of_process_in_i ^ ~link_config_control_i[LINK_CFG_EOP_POL_BIT];

	// strap is caught by a clocked process after release, never by the reset itself
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i)
			strap_r <= 1'b0;
		else
			strap_r <= ready_polarity_strap_i;
	end

	// buffer owner: network keeps the buffer while it asks and no host access is being served
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i)
			net_owner_r <= 1'b0;
		else if (state_r == HB_SERVE || state_r == HB_HOLD)
			net_owner_r <= 1'b0;
		else
			net_owner_r <= net.req;
	end

	// host access sequencer; state and wait count step together
	always_comb begin
		state_nxt = state_r;
		wait_cnt_nxt = wait_cnt_r;
		ready_nxt = 1'b1;
		unique case (state_r)
			HB_IDLE: begin
				if (bmp_access && (net.req || net_owner_r)) begin
					state_nxt = HB_WAIT;
					wait_cnt_nxt = net.err ? ERROR_CNT : CONFLICT_CNT;
					ready_nxt = 1'b0;
				end else if (access) begin
					state_nxt = HB_HOLD;
				end
			end
			HB_WAIT: begin
				ready_nxt = 1'b0;
				if (wait_cnt_r > 9'h002)
					wait_cnt_nxt = wait_cnt_r - 9'h001;
				else begin
					wait_cnt_nxt = WAIT_CNT_ZERO;
					state_nxt = HB_SERVE;
					ready_nxt = 1'b1;
				end
			end
			HB_SERVE: begin
				if (!access)
					state_nxt = HB_IDLE;
			end
			HB_HOLD: begin
				if (!access)
					state_nxt = HB_IDLE;
			end
		endcase
		if (!access && state_r == HB_WAIT) begin
			state_nxt = HB_IDLE;
			wait_cnt_nxt = WAIT_CNT_ZERO;
			ready_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			state_r <= HB_IDLE;
			wait_cnt_r <= WAIT_CNT_ZERO;
			ready_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			wait_cnt_r <= wait_cnt_nxt;
			ready_r <= ready_nxt;
		end
	end

	// ready polarity, straight from a flop
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i)
			channel_wait_output_o <= 1'b0;
		else
			channel_wait_output_o <= strap_r ? ready_nxt : ~ready_nxt;
	end

	// grants to the buffer side
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			host_grant_o <= 1'b0;
			net_grant_o <= 1'b0;
		end else begin
			host_grant_o <= (state_nxt == HB_SERVE) || (state_nxt == HB_HOLD && host.bmp_sel);
			net_grant_o <= net.req && state_nxt != HB_SERVE && !(state_nxt == HB_HOLD && host.bmp_sel);
		end
	end

	// strobe inhibit check, flags a host that re-strobes too soon
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			strobe_prev_r <= 1'b0;
			idle_cnt_r <= 4'hF;
			inhibit_violation_o <= 1'b0;
		end else begin
			strobe_prev_r <= access;
			if (access)
				idle_cnt_r <= 4'h0;
			else if (idle_cnt_r != 4'hF)
				idle_cnt_r <= idle_cnt_r + 4'h1;
			inhibit_violation_o <= access && !strobe_prev_r && (idle_cnt_r < 4'(INHIBIT_CYC));
		end
	end

	// eop registered in active-high sense for the dma side
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i)
			eop_seen_o <= 1'b0;
		else
			eop_seen_o <= eop_act & dma_acknowledge_in_i;
	end

	hbdsp_dma_request_out u_dma_request_out (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.dma_pending_i(dma_pending_i),
		.burst_mode_i(burst_mode_i),
		.dma_acknowledge_in_i(dma_acknowledge_in_i),
		.last_transfer_i(eop_act),
		.next_last_i(next_last_i),
		.transmit_mode_control_i(transmit_mode_control_i),
		.dma_request_out_o(dma_request_out_o)
	);

endmodule

// ---- rtl/hbdsp_pkg.sv ----
package hbdsp_pkg;

	localparam int unsigned CLK_PERIOD_PS = 8000;

	// timing figures in their own units (picoseconds)
	localparam int unsigned RDY_NORMAL_PS = 28000;
	localparam int unsigned RDY_CONFLICT_PS = 175000;
	localparam int unsigned RDY_ERROR_PS = 2150000;
	localparam int unsigned INHIBIT_PS = 50000;
	localparam int unsigned DMA_REQUEST_OUT_DROP_PS = 21000;
	localparam int unsigned DMA_REQUEST_OUT_RAISE_PS = 19000;

	// longest times round down, least times round up, the normal ready time never below one cycle
	localparam int unsigned RDY_NORMAL_CYC = (RDY_NORMAL_PS / CLK_PERIOD_PS) > 0 ? RDY_NORMAL_PS / CLK_PERIOD_PS : 1;
	localparam int unsigned RDY_CONFLICT_CYC = RDY_CONFLICT_PS / CLK_PERIOD_PS;
	localparam int unsigned RDY_ERROR_CYC = RDY_ERROR_PS / CLK_PERIOD_PS;
	localparam int unsigned INHIBIT_CYC = (INHIBIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// control bit positions
	localparam int unsigned LINK_CFG_EOP_POL_BIT = 1;
	localparam int unsigned TX_MODE_EARLY_DMA_REQUEST_OUT_BIT = 2;

	localparam logic [8:0] WAIT_CNT_ZERO = 9'h000;
	localparam logic [8:0] CONFLICT_CNT = 9'(RDY_CONFLICT_CYC);
	localparam logic [8:0] ERROR_CNT = 9'(RDY_ERROR_CYC);

	// host strobes of one access
	typedef struct packed {
		logic rd;
		logic wr;
		logic bmp_sel;
	} hbdsp_host_type;

	// network side view of the buffer
	typedef struct packed {
		logic req;
		logic err;
	} hbdsp_net_type;

	typedef enum logic [1:0] {
		HB_IDLE = 2'b00,
		HB_WAIT = 2'b01,
		HB_SERVE = 2'b10,
		HB_HOLD = 2'b11
	} hbdsp_state_type;

endpackage

// ---- rtl/hbdsp_dma_request_out.sv ----
module hbdsp_dma_request_out
	import hbdsp_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic dma_pending_i,
	input wire logic burst_mode_i,
	input wire logic dma_acknowledge_in_i,
	input wire logic last_transfer_i,
	input wire logic next_last_i,
	input wire logic [7:0] transmit_mode_control_i,
	output logic dma_request_out_o
);

	logic dma_request_out_nxt;

	// request follows pending data, gated by acknowledge and the burst end point
	always_comb begin
		dma_request_out_nxt = dma_pending_i;
		if (!burst_mode_i) begin
			if (dma_acknowledge_in_i)
				dma_request_out_nxt = 1'b0;
		end else begin
			if (transmit_mode_control_i[TX_MODE_EARLY_DMA_REQUEST_OUT_BIT] && next_last_i)
				dma_request_out_nxt = 1'b0;
			if (!transmit_mode_control_i[TX_MODE_EARLY_DMA_REQUEST_OUT_BIT] && last_transfer_i)
				dma_request_out_nxt = 1'b0;
		end
	end

	// one flop keeps drop and raise inside 21 ns and 19 ns at 8 ns clock
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i)
			dma_request_out_o <= 1'b0;
		else
			dma_request_out_o <= dma_request_out_nxt;
	end

endmodule

// ---- verif/hbdsp_host_model.sv ----
module hbdsp_host_model
	import hbdsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rdy_i,
	output logic rd_o,
	output logic wr_o,
	output logic sel_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{rd_o, wr_o, sel_o} = 3'h0;
	end
	// one access held until ready returns; n counts the stalled cycles after the first three
	task automatic acc(input logic w, input logic s, output int n);
		@(negedge clk_i);
		{rd_o, wr_o, sel_o} = {!w, w, s};
		n = 0;
		repeat (3) @(negedge clk_i);
		while (!rdy_i && n < 400) begin
			@(negedge clk_i);
			n++;
		end
		// a released select shows the inverse, not a stale copy
		{rd_o, wr_o, sel_o} = {2'h0, !s};
		repeat (INHIBIT_CYC) @(negedge clk_i);
	endtask
endmodule

// ---- verif/hbdsp_port_chk.sv ----
module hbdsp_port_chk (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic host_read_strobe_i,
	input wire logic host_write_strobe_i,
	input wire logic buffer_memory_port_sel_i,
	input wire logic ready_polarity_strap_i,
	input wire logic net_req_i,
	input wire logic net_err_i,
	input wire logic dma_pending_i,
	input wire logic burst_mode_i,
	input wire logic dma_acknowledge_in_i,
	input wire logic end_of_process_in_i,
	input wire logic next_last_i,
	input wire logic [7:0] link_config_control_i,
	input wire logic [7:0] transmit_mode_control_i,
	input wire logic channel_wait_output_o,
	input wire logic host_grant_o,
	input wire logic net_grant_o,
	input wire logic inhibit_violation_o,
	input wire logic eop_seen_o,
	input wire logic dma_request_out_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// strap is only changed under reset, so this is ready in its active sense
	wire rdy = channel_wait_output_o ~^ ready_polarity_strap_i;
	wire st = host_read_strobe_i | host_write_strobe_i;
	wire cf = buffer_memory_port_sel_i & net_req_i;
	wire ak = dma_acknowledge_in_i;
	wire bm = burst_mode_i;
	wire ea = end_of_process_in_i ~^ link_config_control_i[1];
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	property p_free; $rose(st) && !buffer_memory_port_sel_i |=> rdy[*2]; endproperty
	a_free: assert property (p_free) else $error("access off the port waited");
	property p_conf; $rose(st) && cf && !net_err_i |=> !rdy ##[1:20] rdy; endproperty
	a_conf: assert property (p_conf) else $error("conflict wait wrong");
	property p_err; $rose(st) && cf && net_err_i |=> (!rdy)[*8] ##[1:260] rdy; endproperty
	a_err: assert property (p_err) else $error("error wait wrong");
	property p_pol; (!st)[*3] |-> rdy; endproperty
	a_pol: assert property (p_pol) else $error("idle ready level wrong");
	property p_drop; !bm && $rose(ak) |=> !dma_request_out_o; endproperty
	a_drop: assert property (p_drop) else $error("request kept on ack");
	property p_ret; !bm && !ak && dma_pending_i |=> dma_request_out_o; endproperty
	a_ret: assert property (p_ret) else $error("request not back");
	property p_eop; ak && ea |=> eop_seen_o; endproperty
	a_eop: assert property (p_eop) else $error("eop missed");
	property p_early; bm && ak && transmit_mode_control_i[2] && next_last_i |=> !dma_request_out_o; endproperty
	a_early: assert property (p_early) else $error("early drop missed");
	property p_late; bm && ak && !transmit_mode_control_i[2] && ea |=> !dma_request_out_o; endproperty
	a_late: assert property (p_late) else $error("last drop missed");
	property p_excl; host_grant_o |-> !net_grant_o; endproperty
	a_excl: assert property (p_excl) else $error("both sides granted");
	c_conf: cover property ($rose(st) && cf && !net_err_i);
	c_err: cover property ($rose(st) && cf && net_err_i);
	c_early: cover property (bm && ak && next_last_i);
endmodule
bind hbdsp_port hbdsp_port_chk hbdsp_port_chk_inst (.*);

// ---- verif/hbdsp_port_tb.sv ----
module hbdsp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, strap = 1, nreq = 0, nerr = 0, pend = 0, burst = 0, ack = 0, eop = 0, nl = 0;
	logic [7:0] cfg = 8'h00, tmc = 8'h00;
	logic rd, wr, sel, wt, es, dq, hg, ng, iv;
	int failures = 0, checks_done = 0, w, hgn = 0, ivn = 0;
	// {burst, tx bit2, cfg bit1, eop, next_last, pending, ack, dma_request_out, eop_seen}
	logic [8:0] rows [9] = '{9'h00A, 9'h00D, 9'h000, 9'h06A, 9'h1CE, 9'h1DC, 9'h00A, 9'h15E, 9'h16D};
	always #4 clk = ~clk;
	hbdsp_host_model hbdsp_host_model_inst (.clk_i(clk), .rdy_i(wt ~^ strap), .rd_o(rd), .wr_o(wr), .sel_o(sel));
	hbdsp_port hbdsp_port_inst (.core_clk_i(clk), .rstn_i(rstn), .host_read_strobe_i(rd), .host_write_strobe_i(wr),
		.buffer_memory_port_sel_i(sel), .ready_polarity_strap_i(strap), .net_req_i(nreq), .net_err_i(nerr),
		.dma_pending_i(pend), .burst_mode_i(burst), .dma_acknowledge_in_i(ack), .end_of_process_in_i(eop),
		.next_last_i(nl), .link_config_control_i(cfg), .transmit_mode_control_i(tmc), .channel_wait_output_o(wt),
		.host_grant_o(hg), .net_grant_o(ng), .eop_seen_o(es), .inhibit_violation_o(iv), .dma_request_out_o(dq));
	// pulses are counted so that short ones are not missed between compares
	always @(posedge clk) begin
		if (hg === 1'b1)
			hgn++;
		if (iv === 1'b1)
			ivn++;
	end
	task automatic chk(input logic [8:0] e, input logic [8:0] g, input string n);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s exp %0h got %0h", n, e, g);
		end
	endtask
	// strap may only move while reset is held
	task automatic rst;
		rstn = 0;
		repeat (3) @(negedge clk);
		rstn = 1;
		repeat (4) @(negedge clk);
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// worst path is one error wait plus a few short ones
	initial begin
		#50000;
		failures++;
		conclude();
	end
	initial begin
		rst();
		chk(9'h001, 9'(wt), "idle ready");
		for (int i = 0; i < 9; i++) begin
			@(negedge clk);
			{burst, tmc[2], cfg[1], eop, nl, pend, ack} = rows[i][8:2];
			repeat (2) @(negedge clk);
			chk(9'(rows[i][1:0]), 9'({dq, es}), "dma row");
		end
		hbdsp_host_model_inst.acc(1, 0, w);
		chk(9'h000, 9'(w), "plain write");
		hbdsp_host_model_inst.acc(0, 1, w);
		chk(9'h000, 9'(w), "port read free");
		nreq = 1;
		repeat (2) @(negedge clk);
		chk(9'h001, 9'(ng), "net grant");
		hgn = 0;
		hbdsp_host_model_inst.acc(1, 1, w);
		chk(9'h001, 9'(w > 0 && w < 22), "conflict wait");
		chk(9'h001, 9'(hgn > 0), "host grant");
		nerr = 1;
		hbdsp_host_model_inst.acc(1, 1, w);
		chk(9'h001, 9'(w > 21 && w < 269), "error wait");
		{nreq, nerr, strap} = 3'h0;
		rst();
		chk(9'h000, 9'(wt), "low ready");
		nreq = 1;
		hbdsp_host_model_inst.acc(0, 1, w);
		chk(9'h001, 9'(w > 0 && w < 22), "low conflict");
		chk(9'h000, 9'(ivn), "inhibit flag");
		conclude();
	end
endmodule
